/* logic/tio_defs.svh */
// Constants for the ordered-transaction bus master
`ifndef TIO_DEFS_SVH
`define TIO_DEFS_SVH
`define TIO_ID_W         4
`define TIO_ADDR_W       32
`define TIO_DATA_W       32
`define TIO_RESP_W       2
`define TIO_OUT_MAX      8
`define TIO_CNT_W        4
`define TIO_WR_INTLV     1
`define TIO_FIFO_DEPTH   2
`define TIO_FIFO_PTR_W   1
`define TIO_FIFO_CNT_W   2
`endif

/* logic/tio_pkg.sv */
// Types shared by the ordered-transaction bus master
package tio_pkg;
    typedef enum logic [2:0] {
        TIO_ST_IDLE = 3'h0,
        TIO_ST_HOLD = 3'h1,
        TIO_ST_AW   = 3'h2,
        TIO_ST_W    = 3'h3,
        TIO_ST_AR   = 3'h4
    } tio_state_t;
endpackage

/* logic/tio_stream_if.sv */
// Valid/ready word stream between the master and its buffer
`timescale 1ns/100ps
`default_nettype none
interface tio_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* logic/tio_fifo2.sv */
// Two-entry buffer with registered valid and ready
`include "tio_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tio_fifo2 #(
    parameter int W = 8
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    tio_stream_if.snk in_s,
    tio_stream_if.src out_s
);
    logic [W-1:0]               mem_reg [`TIO_FIFO_DEPTH];
    logic [`TIO_FIFO_PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [`TIO_FIFO_PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [`TIO_FIFO_CNT_W-1:0] cnt_reg, cnt_next;
    logic                       push, pop;

    assign push = in_s.valid && in_s.ready;
    assign pop  = out_s.valid && out_s.ready;
    assign out_s.data = mem_reg[rd_ptr_reg];

    // Pointer and fill count; ready and valid come from the count register
    always_comb begin
        wr_ptr_next = wr_ptr_reg + `TIO_FIFO_PTR_W'(push);
        rd_ptr_next = rd_ptr_reg + `TIO_FIFO_PTR_W'(pop);
        cnt_next    = cnt_reg + `TIO_FIFO_CNT_W'(push) - `TIO_FIFO_CNT_W'(pop);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end

    // Storage needs no reset; valid guards it
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_s.data;
        end
    end

    assign in_s.ready  = (cnt_reg != `TIO_FIFO_CNT_W'(`TIO_FIFO_DEPTH));
    assign out_s.valid = (cnt_reg != '0);
endmodule
`default_nettype wire

/* logic/tio_outstanding.sv */
// Counter of issued but not yet completed transactions
`timescale 1ns/100ps
`default_nettype none
module tio_outstanding #(
    parameter int CNT_W = 4,
    parameter int MAX   = 8
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             inc,
    input  wire logic             dec,
    output var  logic [CNT_W-1:0] count,
    output var  logic             busy,
    output var  logic             full
);
    logic [CNT_W-1:0] cnt_reg, cnt_next;

    // Issue and completion in one cycle cancel out
    always_comb begin
        cnt_next = cnt_reg + CNT_W'(inc) - CNT_W'(dec);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg;
    assign busy  = (cnt_reg != '0);
    assign full  = (cnt_reg >= CNT_W'(MAX));
endmodule
`default_nettype wire

/* logic/tio_master.sv */
// Bus master issuing ID-tagged reads and writes with ordering control
//
// Contract
// - Other masters' transactions are unordered with ours.
// - Different IDs from us need no ordering.
// - Different-ID read beats may interleave.
// - Write data follows write address order.
// - Legacy interleave only when slave depth exceeds one.
// - Reads and writes are mutually unordered.
// - Hold dependent transaction until earlier completes.
// - Write completes only on its response.
// - Master IDs up to four bits.
// - Single-stream master may tie IDs constant.
// - One write's data beats go consecutively.
// - Write interleave depth configured to one.
// - Write data ID derived from address ID.
`include "tio_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tio_master
    import tio_pkg::*;
#(
    parameter int ID_W          = `TIO_ID_W,
    parameter int ADDR_W        = `TIO_ADDR_W,
    parameter int DATA_W        = `TIO_DATA_W,
    parameter int OUT_MAX       = `TIO_OUT_MAX,
    parameter bit SINGLE_STREAM = 1'b0,
    parameter int WR_INTLV      = `TIO_WR_INTLV
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              cmd_valid,
    output var  logic              cmd_ready,
    input  wire logic              cmd_write,
    input  wire logic              cmd_ordered,
    input  wire logic [ID_W-1:0]   cmd_id,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_data,
    output var  logic              rsp_valid,
    input  wire logic              rsp_ready,
    output var  logic [ID_W-1:0]   rsp_id,
    output var  logic [DATA_W-1:0] rsp_data,
    output var  logic [`TIO_RESP_W-1:0] rsp_resp,
    output var  logic              rsp_last,
    output var  logic              wr_done,
    output var  logic [ID_W-1:0]   wr_done_id,
    output var  logic [`TIO_RESP_W-1:0] wr_done_resp,
    output var  logic              awvalid,
    input  wire logic              awready,
    output var  logic [ID_W-1:0]   awid,
    output var  logic [ADDR_W-1:0] awaddr,
    output var  logic              wvalid,
    input  wire logic              wready,
    output var  logic [ID_W-1:0]   wid,
    output var  logic [DATA_W-1:0] wdata,
    output var  logic              wlast,
    input  wire logic              bvalid,
    output var  logic              bready,
    input  wire logic [ID_W-1:0]   bid,
    input  wire logic [`TIO_RESP_W-1:0] bresp,
    output var  logic              arvalid,
    input  wire logic              arready,
    output var  logic [ID_W-1:0]   arid,
    output var  logic [ADDR_W-1:0] araddr,
    input  wire logic              rvalid,
    output var  logic              rready,
    input  wire logic [ID_W-1:0]   rid,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic [`TIO_RESP_W-1:0] rresp,
    input  wire logic              rlast
);
    localparam int RW = ID_W + DATA_W + `TIO_RESP_W + 1;

    tio_state_t        state_reg, state_next;
    logic              write_reg, write_next;
    logic              ord_reg, ord_next;
    logic [ID_W-1:0]   id_reg, id_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic              awvalid_reg, awvalid_next;
    logic              wvalid_reg, wvalid_next;
    logic              arvalid_reg, arvalid_next;
    logic              cmd_ready_reg, cmd_ready_next;
    logic              bready_reg, bready_next;
    logic              wr_done_reg, wr_done_next;
    logic [ID_W-1:0]   wr_done_id_reg, wr_done_id_next;
    logic [`TIO_RESP_W-1:0] wr_done_resp_reg, wr_done_resp_next;
    logic              aw_hs, w_hs, b_hs, ar_hs, r_hs, r_end;
    logic              hold_cond;
    logic [`TIO_CNT_W-1:0] wr_cnt, rd_cnt;
    logic              wr_busy, rd_busy, wr_full, rd_full;

    tio_stream_if #(.W(RW)) rd_in ();
    tio_stream_if #(.W(RW)) rd_out ();

    assign aw_hs = awvalid_reg && awready;
    assign w_hs  = wvalid_reg && wready;
    assign b_hs  = bvalid && bready_reg;
    assign ar_hs = arvalid_reg && arready;
    assign r_hs  = rvalid && rd_in.ready;
    // A read completes only with its last beat
    assign r_end = r_hs && rlast;

    tio_outstanding #(.CNT_W(`TIO_CNT_W), .MAX(OUT_MAX)) u_wr_out (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .inc     (aw_hs),
        .dec     (b_hs),
        .count   (wr_cnt),
        .busy    (wr_busy),
        .full    (wr_full)
    );

    tio_outstanding #(.CNT_W(`TIO_CNT_W), .MAX(OUT_MAX)) u_rd_out (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .inc     (ar_hs),
        .dec     (r_end),
        .count   (rd_cnt),
        .busy    (rd_busy),
        .full    (rd_full)
    );

    // any-ID beats buffered in arrival order; a stall loses none
    assign rd_in.valid = rvalid;
    assign rd_in.data  = {rid, rdata, rresp, rlast};
    assign rd_out.ready = rsp_ready;

    tio_fifo2 #(.W(RW)) u_rd_buf (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .in_s    (rd_in),
        .out_s   (rd_out)
    );

    always_comb begin
        if (write_reg) begin
            hold_cond = wr_full || (ord_reg && rd_busy);
        end else begin
            hold_cond = rd_full || (ord_reg && wr_busy);
        end
    end

    // one transaction at a time, never interleaved
    always_comb begin
        state_next   = state_reg;
        write_next   = write_reg;
        ord_next     = ord_reg;
        id_next      = id_reg;
        addr_next    = addr_reg;
        data_next    = data_reg;
        awvalid_next = awvalid_reg;
        wvalid_next  = wvalid_reg;
        arvalid_next = arvalid_reg;
        case (state_reg)
            TIO_ST_IDLE: begin
                if (cmd_valid && cmd_ready_reg) begin
                    write_next = cmd_write;
                    ord_next   = cmd_ordered;
                    // four-bit IDs, single stream ties low
                    id_next    = SINGLE_STREAM ? '0 : cmd_id;
                    addr_next  = cmd_addr;
                    data_next  = cmd_data;
                    state_next = TIO_ST_HOLD;
                end
            end
            TIO_ST_HOLD: begin
                if (!hold_cond) begin
                    if (write_reg) begin
                        awvalid_next = 1'b1;
                        state_next   = TIO_ST_AW;
                    end else begin
                        arvalid_next = 1'b1;
                        state_next   = TIO_ST_AR;
                    end
                end
            end
            TIO_ST_AW: begin
                if (awready) begin
                    awvalid_next = 1'b0;
                    wvalid_next  = 1'b1;
                    state_next   = TIO_ST_W;
                end
            end
            TIO_ST_W: begin
                if (wready) begin
                    wvalid_next = 1'b0;
                    state_next  = TIO_ST_IDLE;
                end
            end
            TIO_ST_AR: begin
                if (arready) begin
                    arvalid_next = 1'b0;
                    state_next   = TIO_ST_IDLE;
                end
            end
            default: begin
                awvalid_next = 1'b0;
                wvalid_next  = 1'b0;
                arvalid_next = 1'b0;
                state_next   = TIO_ST_IDLE;
            end
        endcase
        cmd_ready_next = (state_next == TIO_ST_IDLE);
    end

    // Write response reporting; responses are always accepted
    always_comb begin
        bready_next       = 1'b1;
        wr_done_next      = b_hs;
        wr_done_id_next   = b_hs ? bid : wr_done_id_reg;
        wr_done_resp_next = b_hs ? bresp : wr_done_resp_reg;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg        <= TIO_ST_IDLE;
            write_reg        <= 1'b0;
            ord_reg          <= 1'b0;
            id_reg           <= '0;
            addr_reg         <= '0;
            data_reg         <= '0;
            awvalid_reg      <= 1'b0;
            wvalid_reg       <= 1'b0;
            arvalid_reg      <= 1'b0;
            cmd_ready_reg    <= 1'b0;
            bready_reg       <= 1'b0;
            wr_done_reg      <= 1'b0;
            wr_done_id_reg   <= '0;
            wr_done_resp_reg <= '0;
        end else begin
            state_reg        <= state_next;
            write_reg        <= write_next;
            ord_reg          <= ord_next;
            id_reg           <= id_next;
            addr_reg         <= addr_next;
            data_reg         <= data_next;
            awvalid_reg      <= awvalid_next;
            wvalid_reg       <= wvalid_next;
            arvalid_reg      <= arvalid_next;
            cmd_ready_reg    <= cmd_ready_next;
            bready_reg       <= bready_next;
            wr_done_reg      <= wr_done_next;
            wr_done_id_reg   <= wr_done_id_next;
            wr_done_resp_reg <= wr_done_resp_next;
        end
    end

    assign cmd_ready    = cmd_ready_reg;
    assign awvalid      = awvalid_reg;
    assign awid         = id_reg;
    assign awaddr       = addr_reg;
    assign wvalid       = wvalid_reg;
    // write data ID from address ID
    assign wid          = id_reg;
    assign wdata        = data_reg;
    // Every write is a single beat, so last marks every beat
    assign wlast        = wvalid_reg;
    assign arvalid      = arvalid_reg;
    assign arid         = id_reg;
    assign araddr       = addr_reg;
    assign bready       = bready_reg;
    assign rready       = rd_in.ready;
    assign wr_done      = wr_done_reg;
    assign wr_done_id   = wr_done_id_reg;
    assign wr_done_resp = wr_done_resp_reg;
    assign rsp_valid    = rd_out.valid;
    assign {rsp_id, rsp_data, rsp_resp, rsp_last} = rd_out.data;

    sequence s_aw_hs;
        awvalid && awready;
    endsequence

    sequence s_w_beat;
        wvalid ##0 wlast;
    endsequence

    property p_w_after_aw;
        @(posedge mclk) disable iff (sys_rst) s_aw_hs |=> s_w_beat;
    endproperty
    a_w_after_aw: assert property (p_w_after_aw) else $error("write data not after address");
    property p_w_stable;
        @(posedge mclk) disable iff (sys_rst)
            wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wid);
    endproperty
    a_w_stable: assert property (p_w_stable) else $error("write beat dropped or changed");
    property p_wid_awid;
        @(posedge mclk) disable iff (sys_rst) wvalid |-> wid == $past(awid) && !awvalid;
    endproperty
    a_wid_awid: assert property (p_wid_awid) else $error("write data ID differs from address ID");
    property p_single_id;
        @(posedge mclk) disable iff (sys_rst) SINGLE_STREAM |-> awid == '0 && arid == '0;
    endproperty
    a_single_id: assert property (p_single_id) else $error("single stream ID not zero");
    property p_ord_hold;
        @(posedge mclk) disable iff (sys_rst)
            $rose(awvalid) && ord_reg |-> $past(rd_cnt) == '0;
    endproperty
    a_ord_hold: assert property (p_ord_hold) else $error("ordered write issued over open read");
    property p_wr_open;
        @(posedge mclk) disable iff (sys_rst)
            s_aw_hs ##1 (wvalid && wready && !bvalid) |=> wr_cnt != '0;
    endproperty
    a_wr_open: assert property (p_wr_open) else $error("write closed before response");
    property p_no_intlv;
        @(posedge mclk) disable iff (sys_rst)
            WR_INTLV == 1 |-> !(wvalid && awvalid) && !(wvalid && arvalid);
    endproperty
    a_no_intlv: assert property (p_no_intlv) else $error("write data overlapped another phase");
    property p_bdone;
        @(posedge mclk) disable iff (sys_rst)
            bvalid && bready |=> wr_done && wr_done_id == $past(bid);
    endproperty
    a_bdone: assert property (p_bdone) else $error("write response not reported");
    property p_rd_kept;
        @(posedge mclk) disable iff (sys_rst)
            rvalid && rready && !rsp_valid |=> rsp_valid && rsp_id == $past(rid);
    endproperty
    a_rd_kept: assert property (p_rd_kept) else $error("read beat lost in buffer");
endmodule
`default_nettype wire

/* verif/tio_slave_model.sv */
// Behavioural in-order slave answering the transaction master
`timescale 1ns/100ps
`default_nettype none
module tio_slave_model (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        slow,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [3:0]  awid,
    input  wire logic [31:0] awaddr,
    input  wire logic        wvalid,
    output var  logic        wready,
    input  wire logic [31:0] wdata,
    output var  logic        bvalid,
    input  wire logic        bready,
    output var  logic [3:0]  bid,
    output var  logic [1:0]  bresp,
    input  wire logic        arvalid,
    output var  logic        arready,
    input  wire logic [3:0]  arid,
    input  wire logic [31:0] araddr,
    output var  logic        rvalid,
    input  wire logic        rready,
    output var  logic [3:0]  rid,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rlast,
    output var  int          pend_b,
    output var  int          pend_r
);
    logic [35:0] awq[$];
    logic [3:0]  bq[$];
    logic [35:0] arq[$];
    logic [31:0] mem[logic [31:0]];
    logic [31:0] junk;
    logic        bhs;
    logic        rhs;
    // Sample at each edge, drive 1 ns later; released lines carry junk, not old values
    initial begin
        junk = 32'h1357_9BDF;
        {awready, wready, bvalid, arready, rvalid} = 5'h00;
        {bid, bresp, rid, rdata, rresp, rlast} = 45'h0;
        pend_b = 0;
        pend_r = 0;
        forever begin
            @(posedge mclk);
            bhs = bvalid && bready;
            rhs = rvalid && rready;
            if (sys_rst) begin
                awq.delete();
                bq.delete();
                arq.delete();
            end else begin
                if (awvalid && awready) awq.push_back({awid, awaddr});
                if (wvalid && wready && awq.size() > 0) begin
                    mem[awq[0][31:0]] = wdata;
                    bq.push_back(awq[0][35:32]);
                    void'(awq.pop_front());
                end
                // Read data is fixed when the address is taken; later writes cannot leak in
                if (arvalid && arready)
                    arq.push_back({arid, mem.exists(araddr) ? mem[araddr] : ~araddr});
                if (bhs) void'(bq.pop_front());
                if (rhs) void'(arq.pop_front());
            end
            #1;
            junk = junk * 32'h0019_660D + 32'h3C6E_F35F;
            pend_b = awq.size() + bq.size();
            pend_r = arq.size();
            awready = !sys_rst && (!slow || junk[20]);
            arready = !sys_rst && (!slow || junk[21]);
            wready = !sys_rst;
            // depth one, answers leave in arrival order
            if (!bvalid || bhs || sys_rst) begin
                bvalid = !sys_rst && bq.size() > 0 && (!slow || junk[22]);
                bid = bvalid ? bq[0] : junk[3:0];
                bresp = bvalid ? 2'h0 : junk[5:4];
            end
            if (!rvalid || rhs || sys_rst) begin
                rvalid = !sys_rst && arq.size() > 0 && (!slow || junk[23]);
                // returned ID echoes the address ID
                rid = rvalid ? arq[0][35:32] : junk[7:4];
                rdata = rvalid ? arq[0][31:0] : junk;
                rresp = rvalid ? 2'h0 : junk[9:8];
                rlast = rvalid ? 1'h1 : junk[10];
            end
        end
    end
endmodule
`default_nettype wire

/* verif/transaction_id_ordering_tb.sv */
// Self-checking bench for the ordered-transaction master
`timescale 1ns/100ps
`default_nettype none
module transaction_id_ordering_tb;
    logic        mclk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        slow = 1'h0;
    logic        hold = 1'h0;
    logic        cmd_valid = 1'h0;
    logic        cmd_write = 1'h0;
    logic        cmd_ordered = 1'h0;
    logic [3:0]  cmd_id = 4'h0;
    logic [31:0] cmd_addr = 32'h0;
    logic [31:0] cmd_data = 32'h0;
    logic        rsp_ready = 1'h0;
    logic        cmd_ready, rsp_valid, rsp_last, wr_done, awvalid, awready, wvalid, wready;
    logic        wlast, bvalid, bready, arvalid, arready, rvalid, rready, rlast;
    logic [3:0]  rsp_id, wr_done_id, awid, wid, bid, arid, rid, last_awid;
    logic [31:0] rsp_data, awaddr, wdata, araddr, rdata, r;
    logic [1:0]  rsp_resp, wr_done_resp, bresp, rresp;
    int          pend_b, pend_r, errors, num_checks;
    integer      seed = 13169;
    logic        ord_rd = 1'h0;
    logic        ord_wr = 1'h0;
    logic [35:0] rexp[$];
    logic [3:0]  bexp[$];
    logic [31:0] tmem[logic [31:0]];

    tio_master dut_u (
        .mclk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_write, .cmd_ordered, .cmd_id, .cmd_addr,
        .cmd_data, .rsp_valid, .rsp_ready, .rsp_id, .rsp_data, .rsp_resp, .rsp_last, .wr_done,
        .wr_done_id, .wr_done_resp, .awvalid, .awready, .awid, .awaddr, .wvalid, .wready, .wid,
        .wdata, .wlast, .bvalid, .bready, .bid, .bresp, .arvalid, .arready, .arid, .araddr,
        .rvalid, .rready, .rid, .rdata, .rresp, .rlast
    );
    tio_slave_model slave_u (
        .mclk, .sys_rst, .slow, .awvalid, .awready, .awid, .awaddr, .wvalid, .wready, .wdata,
        .bvalid, .bready, .bid, .bresp, .arvalid, .arready, .arid, .araddr, .rvalid, .rready,
        .rid, .rdata, .rresp, .rlast, .pend_b, .pend_r
    );

    // 50 MHz bus clock
    always #10 mclk = ~mclk;

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Offer one command, hold it until taken, then note what must come back
    task automatic issue(input logic w, input logic o, input logic [3:0] id,
                         input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        #2;
        {cmd_valid, cmd_write, cmd_ordered, cmd_id, cmd_addr, cmd_data} = {1'h1, w, o, id, a, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!cmd_ready && n < 500);
        check(n >= 500, 0);
        if (w) begin
            tmem[a] = d;
            bexp.push_back(id);
            ord_wr = o;
        end else begin
            rexp.push_back({id, tmem.exists(a) ? tmem[a] : ~a});
            ord_rd = o;
        end
        #2;
        cmd_valid = 1'h0;
    endtask

    // Wait, bounded, until every expected result has come back
    task automatic drain;
        int k;
        k = 0;
        while ((rexp.size() + bexp.size()) > 0 && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        check(rexp.size() + bexp.size(), 0);
    endtask

    // Reader stalls at random; hold keeps it low so the buffer fills
    always @(posedge mclk) begin
        #2;
        rsp_ready = !hold && ($random(seed) % 3 != 0);
    end

    // Every result and dependent issue is matched against the reference
    always @(posedge mclk) begin
        if (rsp_valid && rsp_ready) begin
            if (rexp.size() == 0) check(1, 0);
            else check({rsp_id, rsp_data, rsp_resp, rsp_last}, {rexp.pop_front(), 3'h1});
        end
        if (wr_done) begin
            if (bexp.size() == 0) check(1, 0);
            else check({wr_done_id, wr_done_resp}, {bexp.pop_front(), 2'h0});
        end
        if (awvalid && awready) last_awid = awid;
        if (wvalid && wready) check({wid, wlast}, {last_awid, 1'h1});
        if (arvalid && ord_rd) begin
            check(pend_b, 0); // read after write done
            ord_rd = 1'h0;
        end
        if (awvalid && ord_wr) begin
            check(pend_r, 0); // write after read done
            ord_wr = 1'h0;
        end
    end

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #400_000;
        errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge mclk);
        check({cmd_ready, bready, awvalid, wvalid, arvalid, rsp_valid}, 6'h00);
        repeat (5) @(posedge mclk);
        #2;
        sys_rst = 1'h0;
        repeat (2) @(posedge mclk);
        check({cmd_ready, bready, rready, awvalid, wvalid, arvalid, rsp_valid}, 7'h70);
        // Mixed traffic: random IDs, directions, stalls and dependent issues
        for (int i = 0; i < 80; i++) begin
            r = $random(seed);
            slow = r[31];
            issue(r[0], r[3:1] == 3'h0, r[7:4], 32'h0000_1000 + {26'h0, r[13:10], 2'h0},
                  $random(seed));
        end
        // Slow slave with same-ID dependent accesses both ways
        slow = 1'h1;
        for (int i = 0; i < 4; i++) begin
            issue(1'h1, 1'h0, 4'h3, 32'h0000_2000, 32'hCAFE_0000 + i);
            issue(1'h0, 1'h1, 4'h3, 32'h0000_2000, 32'h0);
            issue(1'h1, 1'h1, 4'h3, 32'h0000_2004, 32'h0000_0100 + i);
        end
        drain();
        // Stopped reader: two beats buffered, the third refused at the bus
        slow = 1'h0;
        @(posedge mclk);
        #1;
        hold = 1'h1;
        for (int i = 0; i < 3; i++) issue(1'h0, 1'h0, 4'(i), 32'h0000_1000 + 4 * i, 32'h0);
        repeat (10) @(posedge mclk);
        check({rready, rsp_valid, rsp_id}, 6'h10); // oldest beat held first
        #1;
        hold = 1'h0;
        drain();
        final_report();
    end
endmodule
`default_nettype wire
